// ### hw/scan_watchdog.sv
// scan watchdog: reloaded by every crate access, expires at zero
`timescale 1ns/1ps
module scan_watchdog
  import shutdown_node_pkg::*;
#(
  parameter int unsigned BASE_CYCLES = WDT_BASE_CYC
) (
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rstn_i,
  // control
  input  wire logic       kick_i,
  input  wire logic [3:0] sel_i,
  output logic            expired_o
);

  logic [31:0] count_q;
  logic [31:0] count_d;
  logic        expired_q;
  logic        expired_d;

  always_comb begin
    if (kick_i) begin
      count_d = 32'(BASE_CYCLES) << sel_i;
    end else if (count_q != 32'h0) begin
      count_d = count_q - 32'h1;
    end else begin
      count_d = count_q;
    end
    expired_d = (count_d == 32'h0);
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_q   <= 32'(BASE_CYCLES);
      expired_q <= 1'b0;
    end else begin
      count_q   <= count_d;
      expired_q <= expired_d;
    end
  end

  assign expired_o = expired_q;

endmodule : scan_watchdog

// ### hw/shutdown_node.sv
// shutdown node top: command decoder, fault latch, permission and alarm logic
`timescale 1ns/1ps
module shutdown_node
  import shutdown_node_pkg::*;
#(
  parameter int unsigned WDT_BASE_CYCLES = WDT_BASE_CYC
) (
  // clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  rstn_i,
  // crate controller command port
  input  wire logic                  station_sel_i,
  input  wire logic                  cmd_strobe_i,
  input  wire cmd_t                  cmd_i,
  output rsp_t                       rsp_o,
  // fault inputs
  input  wire logic [GROUP_CH-1:0]   opt_wave_i,
  input  wire logic [GROUP_CH-1:0]   ext_wave_i,
  input  wire logic                  bp_line_i,
  // watchdog timeout switches
  input  wire logic [3:0]            wdt_sel_i,
  // outputs
  output logic                       permission_waveform_out_o,
  output logic                       aux_permission_o,
  output logic                       bp_line_o,
  output logic                       bp_line_oe_o,
  output logic                       bp_source_o,
  output logic                       wdt_expired_o
);

  // channel status
  logic [NUM_CH-1:0] raw_fault;
  logic [NUM_CH-1:0] live_fault;
  logic [NUM_CH-1:0] unmasked;
  logic              any_fault;
  logic              bp_fault;
  logic              wdt_fault;
  logic              access;
  logic              do_clear;

  // registers
  trip_state_t       state_q;
  trip_state_t       state_d;
  logic [15:0]       fault_q;
  logic [15:0]       fault_d;
  logic [15:0]       mask_q;
  logic [15:0]       mask_d;
  logic [15:0]       loop_q;
  logic [15:0]       loop_d;
  logic [15:0]       snap_q;
  logic [15:0]       snap_d;
  logic [3:0]        lat_q;
  logic [3:0]        lat_d;
  rsp_t              rsp_q;
  rsp_t              rsp_d;

  // permission and backplane alarm
  logic              perm_q;
  logic              perm_d;
  logic              src_q;
  logic              src_d;
  logic [3:0]        alarm_q;
  logic [3:0]        alarm_d;
  logic              pull_q;
  logic              pull_d;
  logic [3:0]        blank_q;
  logic [3:0]        blank_d;
  logic              alarm_due;

  // input channels, optical and isolated electrical
  for (genvar i = 0; i < GROUP_CH; i++) begin : g_chan
    wave_presence_detector u_opt (
      .core_clk_i (core_clk_i),
      .rstn_i     (rstn_i),
      .wave_i     (opt_wave_i[i]),
      .fault_o    (raw_fault[BIT_OPT_LO+i])
    );
    wave_presence_detector u_ext (
      .core_clk_i (core_clk_i),
      .rstn_i     (rstn_i),
      .wave_i     (ext_wave_i[i]),
      .fault_o    (raw_fault[BIT_EXT_LO+i])
    );
  end

  wave_presence_detector u_bp (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .wave_i     (bp_line_i),
    .fault_o    (bp_fault)
  );

  scan_watchdog #(
    .BASE_CYCLES (WDT_BASE_CYCLES)
  ) u_wdt (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .kick_i     (access),
    .sel_i      (wdt_sel_i),
    .expired_o  (wdt_fault)
  );

  // ends of the vector come from the watchdog and the line detector
  assign raw_fault[BIT_WDT] = wdt_fault;
  assign raw_fault[BIT_BP]  = bp_fault;
  assign access   = cmd_strobe_i & station_sel_i;
  assign do_clear = access & cmd_is(cmd_i, FN_CLEAR, SUB_FAULT);

  always_comb begin
    live_fault          = raw_fault;
    live_fault[BIT_WDT] = wdt_fault;
    // our own pull on the backplane line must not read back as a fault
    live_fault[BIT_BP]  = bp_fault & ~pull_q & (blank_q == 4'h0);
    unmasked            = live_fault & ~mask_q;
    any_fault           = |unmasked;
  end

  // trip state machine and fault register
  always_comb begin
    state_d = state_q;
    fault_d = fault_q;
    snap_d  = snap_q;
    lat_d   = 4'h0;
    case (state_q)
      ST_ARMED: begin
        if (any_fault) begin
          // capture only the channels bad at first sight, so later ones do not blur the first
          snap_d  = unmasked;
          state_d = ST_PENDING;
        end
      end
      ST_PENDING: begin
        if (!any_fault) begin
          state_d = ST_ARMED;
        end else if (lat_q == LATCH_CNT - 4'h1) begin
          state_d = ST_TRIPPED;
          fault_d = snap_q;
        end else begin
          lat_d = lat_q + 4'h1;
        end
      end
      ST_TRIPPED: begin
        state_d = ST_TRIPPED;
      end
      default: begin
        state_d = ST_TRIPPED;
      end
    endcase
    if (do_clear) begin
      lat_d = 4'h0;
      if (any_fault) begin
        fault_d = live_fault;
        snap_d  = unmasked;
        state_d = ST_TRIPPED;
      end else if (state_q != ST_ARMED) begin
        state_d = ST_ARMED;
      end else begin
        fault_d = live_fault;
      end
    end
  end

  // command decoder and register file
  always_comb begin
    mask_d = mask_q;
    loop_d = loop_q;
    rsp_d  = rsp_q;
    if (access) begin
      rsp_d.rdata = 16'h0000;
      rsp_d.q     = 1'b1;
      rsp_d.x     = 1'b1;
      if (cmd_is(cmd_i, FN_READ, SUB_FAULT)) begin
        rsp_d.rdata = fault_q;
      end else if (cmd_is(cmd_i, FN_READ, SUB_MASK)) begin
        rsp_d.rdata = mask_q;
      end else if (cmd_is(cmd_i, FN_READ, SUB_LOOP)) begin
        rsp_d.rdata = loop_q;
      end else if (cmd_is(cmd_i, FN_WRITE, SUB_FAULT)) begin
        rsp_d.q = 1'b1;
      end else if (cmd_is(cmd_i, FN_WRITE, SUB_MASK)) begin
        mask_d = cmd_i.wdata;
      end else if (cmd_is(cmd_i, FN_WRITE, SUB_LOOP)) begin
        loop_d = cmd_i.wdata;
      end else if (do_clear) begin
        rsp_d.q = 1'b1;
      end else begin
        rsp_d.q = 1'b0;
        rsp_d.x = 1'b0;
      end
    end
  end

  // permission waveform and backplane alarm
  always_comb begin
    // a 10 MHz toggle gives the 5 MHz square; on a trip it freezes at its level
    if (state_q == ST_ARMED && !any_fault) begin
      perm_d = ~perm_q;
    end else begin
      perm_d = perm_q;
    end
    src_d     = ~src_q;
    alarm_due = (state_q != ST_ARMED) && ((snap_q & EXT_GROUP_MASK) != 16'h0000);
    if (alarm_due) begin
      alarm_d = sat_inc(alarm_q, ALARM_CNT);
    end else begin
      alarm_d = 4'h0;
    end
    pull_d = alarm_due && (alarm_q == ALARM_CNT);
    // after release the line's own detector needs time to see the wave again
    if (pull_q && !pull_d) begin
      blank_d = MISS_CNT + 4'h1;
    end else if (blank_q != 4'h0) begin
      blank_d = blank_q - 4'h1;
    end else begin
      blank_d = blank_q;
    end
  end

  // power-up holds permission off until a clear command arms the node
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= ST_TRIPPED;
      fault_q <= FAULT_RST;
      snap_q  <= FAULT_RST;
      lat_q   <= 4'h0;
    end else begin
      state_q <= state_d;
      fault_q <= fault_d;
      snap_q  <= snap_d;
      lat_q   <= lat_d;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mask_q <= MASK_RST;
      loop_q <= LOOP_RST;
      rsp_q  <= '0;
    end else begin
      mask_q <= mask_d;
      loop_q <= loop_d;
      rsp_q  <= rsp_d;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      perm_q  <= 1'b0;
      src_q   <= 1'b0;
      alarm_q <= 4'h0;
      pull_q  <= 1'b0;
      blank_q <= 4'h0;
    end else begin
      perm_q  <= perm_d;
      src_q   <= src_d;
      alarm_q <= alarm_d;
      pull_q  <= pull_d;
      blank_q <= blank_d;
    end
  end

  assign permission_waveform_out_o = perm_q;
  assign aux_permission_o          = perm_q;
  // open drain: only ever drives low, enable carries the alarm
  assign bp_line_o                 = 1'b0;
  assign bp_line_oe_o              = pull_q;
  assign bp_source_o               = src_q;
  assign wdt_expired_o             = wdt_fault;
  assign rsp_o                     = rsp_q;

endmodule : shutdown_node

// ### hw/shutdown_node_pkg.sv
// constants, types and helpers shared by the shutdown node design
// Behaviour
// - read at subaddress 0, 1, 2 returns fault, mask or readback word.
// - write at subaddress 0 is accepted and changes nothing.
// - write at subaddress 1 loads the mask, allowed at any time.
// - write at subaddress 2 stores the readback word, read returns it.
// - clear command reloads fault register with present status of all inputs.
// - with no faults, first clear restores permission only; second clears register.
// - a channel faults when its input stops toggling like a 5 MHz wave.
// - any crate access reloads the watchdog; reaching zero is a fault.
// - watchdog timeout doubles per switch step from 6.55 ms to 214.6 s.
// - all unmasked inputs good and armed: output a 5 MHz permission square wave.
// - permission output stops within 10 us of any input alarm.
// - lost input detected within two cycles; fault latched two or three later.
// - first failing channel recorded when faults are over 1.2 us apart.
// - while tripped no new fault is latched or recorded until a clear.
// - fault read gives first fault after trip, current status after clear.
// - clear with no unmasked fault re-arms; otherwise loads faults and stays off.
// - bit 0 watchdog, bits 1-7 optical, 8-14 electrical, 15 backplane line.
// - about 1 us after an optical or electrical fault, pull backplane line low.
// - a set mask bit stops its channel from faulting or removing permission.
package shutdown_node_pkg;

  // clock and timing
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned MISS_TIME_NS   = 400;   // two missing 5 MHz cycles
  localparam int unsigned MISS_CYC       = MISS_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned LATCH_TIME_NS  = 400;   // two further input cycles
  localparam int unsigned LATCH_CYC      = LATCH_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned ALARM_TIME_NS  = 1000;  // backplane alarm delay
  localparam int unsigned ALARM_CYC      = ALARM_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned WDT_BASE_NS    = 6550000;  // 6.55 ms at switch 0
  localparam int unsigned WDT_BASE_CYC   = WDT_BASE_NS / CLK_PERIOD_NS;

  localparam logic [3:0]  MISS_CNT       = 4'(MISS_CYC);
  localparam logic [3:0]  LATCH_CNT      = 4'(LATCH_CYC);
  localparam logic [3:0]  ALARM_CNT      = 4'(ALARM_CYC);

  // fault and mask layout
  localparam int unsigned NUM_CH         = 16;
  localparam int unsigned BIT_WDT        = 0;
  localparam int unsigned BIT_OPT_LO     = 1;
  localparam int unsigned BIT_EXT_LO     = 8;
  localparam int unsigned BIT_BP         = 15;
  localparam int unsigned GROUP_CH       = 7;
  localparam logic [15:0] EXT_GROUP_MASK = 16'h7ffe;

  // command codes and subaddresses
  localparam logic [4:0]  FN_READ        = 5'h00;
  localparam logic [4:0]  FN_CLEAR       = 5'h09;
  localparam logic [4:0]  FN_WRITE       = 5'h10;
  localparam logic [3:0]  SUB_FAULT      = 4'h0;
  localparam logic [3:0]  SUB_MASK       = 4'h1;
  localparam logic [3:0]  SUB_LOOP       = 4'h2;

  // reset values
  localparam logic [15:0] FAULT_RST      = 16'h0000;
  localparam logic [15:0] MASK_RST       = 16'h0000;
  localparam logic [15:0] LOOP_RST       = 16'h0000;

  typedef struct packed {
    logic [4:0]  fn;
    logic [3:0]  sub;
    logic [15:0] wdata;
  } cmd_t;

  typedef struct packed {
    logic [15:0] rdata;
    logic        q;
    logic        x;
  } rsp_t;

  typedef enum logic [1:0] {
    ST_ARMED,
    ST_PENDING,
    ST_TRIPPED
  } trip_state_t;

  function automatic logic cmd_is(input cmd_t c, input logic [4:0] fn, input logic [3:0] sub);
    cmd_is = (c.fn == fn) && (c.sub == sub);
  endfunction : cmd_is

  function automatic logic [3:0] sat_inc(input logic [3:0] v, input logic [3:0] lim);
    sat_inc = (v == lim) ? v : v + 4'h1;
  endfunction : sat_inc

endpackage : shutdown_node_pkg

// ### hw/wave_presence_detector.sv
// one input channel: synchroniser and missing-edge detector
`timescale 1ns/1ps
module wave_presence_detector
  import shutdown_node_pkg::*;
(
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rstn_i,
  // channel
  input  wire logic wave_i,
  output logic      fault_o
);

  logic [1:0] sync_q;
  logic [1:0] sync_d;
  logic       prev_q;
  logic       prev_d;
  logic [3:0] gap_q;
  logic [3:0] gap_d;
  logic       fault_q;
  logic       fault_d;

  always_comb begin
    sync_d  = {sync_q[0], wave_i};
    prev_d  = sync_q[1];
    // any edge proves the wave alive; stuck high or low lets the gap grow
    if (sync_q[1] != prev_q) begin
      gap_d = 4'h0;
    end else begin
      gap_d = sat_inc(gap_q, MISS_CNT);
    end
    fault_d = (gap_d == MISS_CNT);
  end

  // channels come up faulted: a wave must prove itself first
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_q  <= 2'h0;
      prev_q  <= 1'b0;
      gap_q   <= MISS_CNT;
      fault_q <= 1'b1;
    end else begin
      sync_q  <= sync_d;
      prev_q  <= prev_d;
      gap_q   <= gap_d;
      fault_q <= fault_d;
    end
  end

  assign fault_o = fault_q;

endmodule : wave_presence_detector

// ### sim/fault_source_model.sv
// upstream fault sources: 5 MHz waves and backplane line level
`timescale 1ns/1ps
module fault_source_model
  import shutdown_node_pkg::*;
(
  // clock and control
  input  wire logic                  core_clk_i,
  input  wire logic [2*GROUP_CH-1:0] stop_i,
  input  wire logic                  gnd_i,
  // backplane drive from the node
  input  wire logic                  bp_oe_i,
  input  wire logic                  bp_src_i,
  // waves toward the node
  output logic [GROUP_CH-1:0]        opt_o,
  output logic [GROUP_CH-1:0]        ext_o,
  output logic                       bp_o
);
  logic ph = 1'b0;
  always @(negedge core_clk_i) ph <= ~ph;
  // stopped channels stick at alternating levels, so both stuck-high and stuck-low occur
  assign {ext_o, opt_o} = ({2*GROUP_CH{ph}} & ~stop_i) | (stop_i & 14'h2aaa);
  // a source on a wave input never also grounds the shared line
  assign bp_o = (bp_oe_i || (gnd_i && stop_i == '0)) ? 1'b0 : bp_src_i;
endmodule : fault_source_model

// ### sim/shutdown_node_chk.sv
// concurrent checks on the shutdown node ports
`timescale 1ns/1ps
module shutdown_node_chk
  import shutdown_node_pkg::*;
#(
  parameter int unsigned WDT_BASE_CYCLES = WDT_BASE_CYC
) (
  // clock, reset and command port
  input wire logic                core_clk_i,
  input wire logic                rstn_i,
  input wire logic                station_sel_i,
  input wire logic                cmd_strobe_i,
  input wire cmd_t                cmd_i,
  input wire rsp_t                rsp_o,
  // watched inputs and outputs
  input wire logic [GROUP_CH-1:0] opt_wave_i,
  input wire logic [3:0]          wdt_sel_i,
  input wire logic                permission_waveform_out_o,
  input wire logic                aux_permission_o,
  input wire logic                bp_line_o,
  input wire logic                bp_line_oe_o,
  input wire logic                wdt_expired_o
);
  logic                acc;
  logic [15:0]         msk_q, msk_d;
  logic [31:0]         idle_q, idle_d, lim_q, lim_d;
  logic [GROUP_CH-1:0] op_q;
  logic [3:0]          stk_q, stk_d;
  logic [4:0]          frz_q, frz_d;
  logic                pm_q;
  assign acc = cmd_strobe_i && station_sel_i;
  always_comb begin
    msk_d = msk_q;
    if (acc && cmd_i.fn == FN_WRITE && cmd_i.sub == SUB_MASK) msk_d = cmd_i.wdata;
    idle_d = acc ? 32'h0 : idle_q + 32'h1;
    lim_d = acc ? (32'(WDT_BASE_CYCLES) << wdt_sel_i) : lim_q;
    // a good channel changes level on every clock
    stk_d = |(~(opt_wave_i ^ op_q) & ~msk_q[7:1]) ? stk_q + {3'h0, stk_q != 4'hf} : 4'h0;
    frz_d = (permission_waveform_out_o == pm_q) ? frz_q + {4'h0, frz_q != 5'h1f} : 5'h0;
  end
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      msk_q <= MASK_RST;
      idle_q <= 32'h0;
      lim_q <= 32'(WDT_BASE_CYCLES);
      op_q <= '0;
      stk_q <= 4'h0;
      frz_q <= 5'h0;
      pm_q <= 1'b0;
    end else begin
      msk_q <= msk_d;
      idle_q <= idle_d;
      lim_q <= lim_d;
      op_q <= opt_wave_i;
      stk_q <= stk_d;
      frz_q <= frz_d;
      pm_q <= permission_waveform_out_o;
    end
  end
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);
  sequence s_cmd(f, s);
    acc && cmd_i.fn == f && cmd_i.sub == s;
  endsequence
  sequence s_frozen;
    $stable(permission_waveform_out_o);
  endsequence
  AST_RD_MASK: assert property (s_cmd(FN_READ, SUB_MASK) |=> rsp_o.rdata == $past(msk_q))
    else $error("mask read differs from last write");
  AST_NOP_ACK: assert property (s_cmd(FN_WRITE, SUB_FAULT) |=> rsp_o.q && rsp_o.x)
    else $error("no-op write not acknowledged");
  AST_REFUSED: assert property (acc && cmd_i.fn == 5'h01 |=> !rsp_o.q && !rsp_o.x && rsp_o.rdata == 16'h0)
    else $error("unsupported command answered");
  AST_RSP_HOLD: assert property (!acc |=> $stable(rsp_o))
    else $error("answer changed without access");
  AST_AUX_SAME: assert property (aux_permission_o == permission_waveform_out_o)
    else $error("auxiliary permission differs");
  AST_STUCK_STOP: assert property (stk_q >= 4'ha |-> s_frozen)
    else $error("permission runs with a stuck channel");
  AST_BP_DELAY: assert property ($rose(bp_line_oe_o) |-> frz_q >= 5'h8 && bp_line_o == 1'b0)
    else $error("backplane pull too early");
  AST_WDT_LATE: assert property (idle_q >= lim_q + 32'h3 |-> wdt_expired_o)
    else $error("watchdog failed to expire");
  AST_WDT_EARLY: assert property (wdt_expired_o && idle_q > 32'h2 |-> idle_q + 32'h3 >= lim_q)
    else $error("watchdog expired early");
endmodule : shutdown_node_chk

// ### sim/tb.sv
// self-checking bench for the shutdown node
`timescale 1ns/1ps
module tb;
  import shutdown_node_pkg::*;
  localparam int unsigned WDT = 200;
  logic                core_clk_i, rstn_i, sel, stb, gnd, bp, perm, aux, oe, src, wexp, bpo;
  cmd_t                cmd;
  rsp_t                rsp;
  logic [GROUP_CH-1:0] opt, ext;
  logic [13:0]         stop;
  logic [3:0]          wsel;
  logic [31:0]         seed;
  logic [15:0]         m, w;
  int                  mismatches, checks, k, j, n;
  shutdown_node #(.WDT_BASE_CYCLES(WDT)) dut (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .station_sel_i(sel), .cmd_strobe_i(stb), .cmd_i(cmd), .rsp_o(rsp),
    .opt_wave_i(opt), .ext_wave_i(ext), .bp_line_i(bp), .wdt_sel_i(wsel), .permission_waveform_out_o(perm),
    .aux_permission_o(aux), .bp_line_o(bpo), .bp_line_oe_o(oe), .bp_source_o(src), .wdt_expired_o(wexp));
  fault_source_model u_src (.core_clk_i(core_clk_i), .stop_i(stop), .gnd_i(gnd), .bp_oe_i(oe), .bp_src_i(src),
    .opt_o(opt), .ext_o(ext), .bp_o(bp));
  function automatic logic [15:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction : xs
  function automatic logic [15:0] chbit(input int b);
    return 16'h1 << b;
  endfunction : chbit
  task automatic complete_run();
    if (mismatches == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk
  task automatic do_cmd(input logic [4:0] f, input logic [3:0] s, input logic [15:0] d);
    stb = 1'b1;
    sel = 1'b1;
    cmd = '{fn: f, sub: s, wdata: d};
    @(negedge core_clk_i);
    stb = 1'b0;
    @(negedge core_clk_i);
  endtask : do_cmd
  task automatic rd(input logic [3:0] s, input logic [15:0] e, input string nm);
    do_cmd(FN_READ, s, 16'h0);
    chk(nm, e, rsp.rdata);
  endtask : rd
  task automatic run_chk(input logic run);
    logic p;
    p = perm;
    @(negedge core_clk_i);
    chk("permission toggle", {15'h0, run}, {15'h0, perm ^ p});
  endtask : run_chk
  task automatic rearm(input logic [15:0] held);
    do_cmd(FN_CLEAR, SUB_FAULT, 16'h0);
    rd(SUB_FAULT, held, "fault after first clear");
    run_chk(1'b1);
    do_cmd(FN_CLEAR, SUB_FAULT, 16'h0);
    rd(SUB_FAULT, 16'h0, "fault after second clear");
  endtask : rearm
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  initial begin
    {rstn_i, sel, stb, gnd} = 4'h0;
    cmd = '0;
    stop = '0;
    wsel = 4'h0;
    seed = 32'ha1f6;
    mismatches = 0;
    checks = 0;
    repeat (10) @(negedge core_clk_i);
    rstn_i = 1'b1;
    chk("answer after reset", 16'h0, rsp.rdata);
    w[0] = src;
    @(negedge core_clk_i);
    chk("backplane source toggle", 16'h1, {15'h0, src ^ w[0]});
    rd(SUB_FAULT, FAULT_RST, "fault reset value");
    rd(SUB_MASK, MASK_RST, "mask reset value");
    rd(SUB_LOOP, LOOP_RST, "readback reset value");
    for (n = 0; n < 8; n++) begin
      m = (n == 0) ? 16'hffff : xs();
      w = xs();
      do_cmd(FN_WRITE, SUB_MASK, m);
      do_cmd(FN_WRITE, SUB_LOOP, w);
      do_cmd(FN_WRITE, SUB_FAULT, ~m);
      chk("no-op answer", 16'h3, {14'h0, rsp.q, rsp.x});
      do_cmd(5'(n + 1), SUB_MASK, w);
      chk("refused answer", 16'h0, rsp.rdata | {14'h0, rsp.q, rsp.x});
      rd(SUB_MASK, m, "mask");
      rd(SUB_LOOP, w, "readback");
    end
    // watchdog masked while channel faults are exercised
    do_cmd(FN_WRITE, SUB_MASK, 16'h0001);
    do_cmd(FN_CLEAR, SUB_FAULT, 16'h0);
    run_chk(1'b1);
    k = xs() % GROUP_CH;
    j = xs() % GROUP_CH;
    stop[k] = 1'b1;
    for (n = 0; n < 30 && oe !== 1'b1; n++) @(negedge core_clk_i);
    chk("alarm pull", 16'h1, {15'h0, oe});
    if (oe !== 1'b1) complete_run();
    stop[GROUP_CH+j] = 1'b1;
    repeat (25) @(negedge core_clk_i);
    run_chk(1'b0);
    rd(SUB_FAULT, chbit(BIT_OPT_LO + k), "first fault");
    stop = '0;
    repeat (12) @(negedge core_clk_i);
    rearm(chbit(BIT_OPT_LO + k));
    do_cmd(FN_WRITE, SUB_MASK, 16'h0001 | chbit(BIT_EXT_LO + j));
    stop[GROUP_CH+j] = 1'b1;
    repeat (25) @(negedge core_clk_i);
    run_chk(1'b1);
    stop = '0;
    repeat (8) @(negedge core_clk_i);
    do_cmd(FN_WRITE, SUB_MASK, 16'h0001);
    gnd = 1'b1;
    repeat (25) @(negedge core_clk_i);
    do_cmd(FN_CLEAR, SUB_FAULT, 16'h0);
    rd(SUB_FAULT, chbit(BIT_BP), "line alarm");
    run_chk(1'b0);
    gnd = 1'b0;
    repeat (10) @(negedge core_clk_i);
    rearm(chbit(BIT_BP));
    // switch step 1 doubles the timeout
    wsel = 4'h1;
    do_cmd(FN_WRITE, SUB_MASK, 16'h0000);
    repeat (2 * WDT - 20) @(negedge core_clk_i);
    chk("watchdog early", 16'h0, {15'h0, wexp});
    repeat (40) @(negedge core_clk_i);
    chk("watchdog expiry", 16'h1, {15'h0, wexp});
    run_chk(1'b0);
    rd(SUB_FAULT, chbit(BIT_WDT), "watchdog fault");
    rearm(chbit(BIT_WDT));
    complete_run();
  end
endmodule : tb
bind shutdown_node shutdown_node_chk #(.WDT_BASE_CYCLES(WDT_BASE_CYCLES)) u_chk (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .station_sel_i(station_sel_i), .cmd_strobe_i(cmd_strobe_i),
  .cmd_i(cmd_i), .rsp_o(rsp_o), .opt_wave_i(opt_wave_i), .wdt_sel_i(wdt_sel_i),
  .permission_waveform_out_o(permission_waveform_out_o), .aux_permission_o(aux_permission_o),
  .bp_line_o(bp_line_o), .bp_line_oe_o(bp_line_oe_o), .wdt_expired_o(wdt_expired_o));
